// ### logic/pet_pkg.sv
`default_nettype none
package pet_pkg;
  localparam int PET_NUM_PINS     = 16;
  localparam int PET_MAX_ARMED    = 10;
  localparam int PET_NUM_TICKS    = 4;
  localparam int PET_PERIOD_W     = 31;
  localparam int PET_ARMED_W      = 5;
  localparam int PET_CLK_HZ       = 40_000_000;
  localparam int PET_TICK_TIME_MS = 1;
  localparam int PET_MS_CYCLES    = PET_CLK_HZ / 1000 * PET_TICK_TIME_MS;

  // Register byte offsets
  localparam logic [7:0] PET_OFS_OUT_DATA   = 8'h00;
  localparam logic [7:0] PET_OFS_PIN_LEVEL  = 8'h04;
  localparam logic [7:0] PET_OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] PET_OFS_IRQ_MASK   = 8'h0C;
  localparam logic [7:0] PET_OFS_ARMED_CNT  = 8'h10;
  localparam logic [7:0] PET_OFS_TICK_SEL   = 8'h20;
  localparam logic [7:0] PET_OFS_TICK_PER   = 8'h24;
  localparam logic [7:0] PET_OFS_TICK_PAUSE = 8'h28;
  localparam logic [7:0] PET_OFS_TICK_COUNT = 8'h2C;
  localparam logic [1:0] PET_CFG_PAGE       = 2'h1;

  // Pin configuration fields
  localparam int PET_CFG_W        = 6;
  localparam int PET_CFG_MODE_LSB = 0;
  localparam int PET_CFG_MODE_W   = 3;
  localparam int PET_CFG_PULL_LSB = 3;
  localparam int PET_CFG_PULL_W   = 2;
  localparam int PET_CFG_OD_BIT   = 5;

  // Status layout
  localparam int PET_ST_PIN_LSB    = 0;
  localparam int PET_ST_TICK_LSB   = 16;
  localparam int PET_ST_REFUSE_BIT = 20;
  localparam int PET_ST_W          = 21;

  localparam logic [1:0] PET_TICK_DEFAULT = 2'h0;
  localparam logic [2:0] PET_TICK_IDX_MAX = 3'h4;

  typedef enum logic [2:0] {
    OFF_MODE,
    DIGITAL_IN_MODE,
    DIGITAL_OUT_MODE,
    RISING_EDGE_MODE,
    FALLING_EDGE_MODE,
    ANY_EDGE_MODE,
    LEGACY_OPEN_DRAIN_OUTPUT_MODE
  } pet_mode_t;

  typedef enum logic [1:0] {
    PULL_NONE,
    PULL_UP,
    PULL_DOWN
  } pet_pull_t;
endpackage : pet_pkg
`default_nettype wire

// ### logic/pet_edge_det.sv
`default_nettype none
module pet_edge_det
  import pet_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [PET_NUM_PINS-1:0] pin_in,
  input  wire logic [PET_NUM_PINS-1:0] rise_en,
  input  wire logic [PET_NUM_PINS-1:0] fall_en,
  output logic      [PET_NUM_PINS-1:0] level,
  output logic      [PET_NUM_PINS-1:0] edge_evt
);
  logic [PET_NUM_PINS-1:0] meta_r;
  logic [PET_NUM_PINS-1:0] sync_r;
  logic [PET_NUM_PINS-1:0] prev_r;
  logic [PET_NUM_PINS-1:0] evt_r;
  logic [PET_NUM_PINS-1:0] evt_nxt;

  always_comb
  begin
    evt_nxt = (sync_r & ~prev_r & rise_en)
            | (~sync_r & prev_r & fall_en);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      evt_r  <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      evt_r  <= evt_nxt;
    end
  end

  assign level    = sync_r;
  assign edge_evt = evt_r;
endmodule : pet_edge_det
`default_nettype wire

// ### logic/pet_tick_timer.sv
`default_nettype none
module pet_tick_timer
  import pet_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    ms_stb,
  input  wire logic [PET_PERIOD_W-1:0] period,
  input  wire logic                    restart,
  input  wire logic                    pause,
  output logic                         tick_evt,
  output logic      [PET_PERIOD_W-1:0] count
);
  logic [PET_PERIOD_W-1:0] cnt_r;
  logic [PET_PERIOD_W-1:0] cnt_nxt;
  logic                    evt_r;
  logic                    evt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    evt_nxt = 1'b0;
    if (restart || period == '0)
    begin
      cnt_nxt = '0;
    end
    else if (ms_stb && !pause)
    begin
      if (cnt_r >= period - 1'b1)
      begin
        cnt_nxt = '0;
        evt_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      evt_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign tick_evt = evt_r;
  assign count    = cnt_r;
endmodule : pet_tick_timer
`default_nettype wire

// ### logic/pet_top.sv
`default_nettype none
module pet_top
  import pet_pkg::*;
#(
  parameter int MS_CYCLES = PET_MS_CYCLES
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic [PET_NUM_PINS-1:0] pin_in,
  output logic      [PET_NUM_PINS-1:0] pin_out,
  output logic      [PET_NUM_PINS-1:0] pin_oe,
  output logic      [PET_NUM_PINS-1:0] pull_up_en,
  output logic      [PET_NUM_PINS-1:0] pull_dn_en,
  output logic                         irq
);
  localparam int PS_W = $clog2(MS_CYCLES);

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  function automatic pet_mode_t cfg_mode(input logic [PET_CFG_W-1:0] c);
    return pet_mode_t'(c[PET_CFG_MODE_LSB +: PET_CFG_MODE_W]);
  endfunction : cfg_mode

  function automatic logic cfg_is_edge(input logic [PET_CFG_W-1:0] c);
    return cfg_mode(c) inside {RISING_EDGE_MODE, FALLING_EDGE_MODE, ANY_EDGE_MODE};
  endfunction : cfg_is_edge

  function automatic logic is_cfg_addr(input logic [7:0] a);
    return a[7:6] == PET_CFG_PAGE && a[1:0] == 2'h0;
  endfunction : is_cfg_addr

  logic [PS_W-1:0]         ps_cnt_r;
  logic [PS_W-1:0]         ps_cnt_nxt;
  logic                    ms_stb_r;
  logic                    ms_stb_nxt;
  logic                    wait_r;
  logic                    wait_nxt;
  logic [31:0]             rdata_r;
  logic [31:0]             rdata_nxt;
  logic [PET_NUM_PINS-1:0] out_data_r;
  logic [PET_NUM_PINS-1:0] out_data_nxt;
  logic [PET_ST_W-1:0]     status_r;
  logic [PET_ST_W-1:0]     status_nxt;
  logic [PET_ST_W-1:0]     mask_r;
  logic [PET_ST_W-1:0]     mask_nxt;
  logic [1:0]              tick_sel_r;
  logic [1:0]              tick_sel_nxt;
  logic [PET_NUM_TICKS-1:0] pause_r;
  logic [PET_NUM_TICKS-1:0] pause_nxt;
  logic [PET_NUM_TICKS-1:0] restart_r;
  logic [PET_NUM_TICKS-1:0] restart_nxt;
  logic [PET_PERIOD_W-1:0] period_r   [PET_NUM_TICKS];
  logic [PET_PERIOD_W-1:0] period_nxt [PET_NUM_TICKS];
  logic [PET_CFG_W-1:0]    cfg_r      [PET_NUM_PINS];
  logic [PET_CFG_W-1:0]    cfg_nxt    [PET_NUM_PINS];
  logic                    irq_r;
  logic                    irq_nxt;
  logic [PET_ARMED_W-1:0]  armed_cnt;
  logic [PET_ST_W-1:0]     st_set;
  logic [PET_ST_W-1:0]     st_clr;
  logic [31:0]             rd_val;
  logic [31:0]             wmerge;
  logic [PET_CFG_W-1:0]    new_cfg;
  logic [3:0]              cfg_idx;
  logic [PET_NUM_PINS-1:0] rise_en;
  logic [PET_NUM_PINS-1:0] fall_en;
  logic [PET_NUM_PINS-1:0] pin_level;
  logic [PET_NUM_PINS-1:0] pin_edge;
  logic [PET_NUM_TICKS-1:0] tick_evt;
  logic [PET_PERIOD_W-1:0] tick_count [PET_NUM_TICKS];
  logic [PET_NUM_PINS-1:0] pin_out_r;
  logic [PET_NUM_PINS-1:0] pin_out_nxt;
  logic [PET_NUM_PINS-1:0] pin_oe_r;
  logic [PET_NUM_PINS-1:0] pin_oe_nxt;
  logic [PET_NUM_PINS-1:0] pull_up_r;
  logic [PET_NUM_PINS-1:0] pull_up_nxt;
  logic [PET_NUM_PINS-1:0] pull_dn_r;
  logic [PET_NUM_PINS-1:0] pull_dn_nxt;

  always_comb
  begin
    ms_stb_nxt = 1'b0;
    ps_cnt_nxt = ps_cnt_r + 1'b1;
    if (ps_cnt_r == PS_W'(MS_CYCLES - 1))
    begin
      ps_cnt_nxt = '0;
      ms_stb_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ps_cnt_r <= '0;
      ms_stb_r <= 1'b0;
    end
    else
    begin
      ps_cnt_r <= ps_cnt_nxt;
      ms_stb_r <= ms_stb_nxt;
    end
  end

  pet_edge_det u_edge (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (pin_in),
    .rise_en  (rise_en),
    .fall_en  (fall_en),
    .level    (pin_level),
    .edge_evt (pin_edge)
  );

  generate
    for (genvar t = 0; t < PET_NUM_TICKS; t++)
    begin : g_tick
      pet_tick_timer u_tick (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .ms_stb   (ms_stb_r),
        .period   (period_r[t]),
        .restart  (restart_r[t]),
        .pause    (pause_r[t]),
        .tick_evt (tick_evt[t]),
        .count    (tick_count[t])
      );
    end
  endgenerate

  // Edge enables and armed count
  always_comb
  begin
    armed_cnt = '0;
    for (int p = 0; p < PET_NUM_PINS; p++)
    begin
      rise_en[p] = (cfg_mode(cfg_r[p]) == RISING_EDGE_MODE)
                 || (cfg_mode(cfg_r[p]) == ANY_EDGE_MODE);
      fall_en[p] = (cfg_mode(cfg_r[p]) == FALLING_EDGE_MODE)
                 || (cfg_mode(cfg_r[p]) == ANY_EDGE_MODE);
      armed_cnt = armed_cnt + PET_ARMED_W'(cfg_is_edge(cfg_r[p]));
    end
  end

  // Bus slave and registers
  always_comb
  begin
    wait_nxt     = 1'b1;
    rdata_nxt    = rdata_r;
    out_data_nxt = out_data_r;
    mask_nxt     = mask_r;
    tick_sel_nxt = tick_sel_r;
    pause_nxt    = pause_r;
    restart_nxt  = '0;
    period_nxt   = period_r;
    cfg_nxt      = cfg_r;
    st_clr       = '0;
    st_set       = '0;
    st_set[PET_ST_PIN_LSB +: PET_NUM_PINS]   = pin_edge;
    st_set[PET_ST_TICK_LSB +: PET_NUM_TICKS] = tick_evt;
    cfg_idx = avs_address[5:2];
    wmerge  = 32'h0;
    new_cfg = '0;
    rd_val  = 32'h0;
    case (avs_address)
      PET_OFS_OUT_DATA:   rd_val[PET_NUM_PINS-1:0] = out_data_r;
      PET_OFS_PIN_LEVEL:  rd_val[PET_NUM_PINS-1:0] = pin_level;
      PET_OFS_IRQ_STATUS: rd_val[PET_ST_W-1:0] = status_r;
      PET_OFS_IRQ_MASK:   rd_val[PET_ST_W-1:0] = mask_r;
      PET_OFS_ARMED_CNT:  rd_val[PET_ARMED_W-1:0] = armed_cnt;
      PET_OFS_TICK_SEL:   rd_val[2:0] = {1'b0, tick_sel_r} + 3'h1;
      PET_OFS_TICK_PER:   rd_val[PET_PERIOD_W-1:0] = period_r[tick_sel_r];
      PET_OFS_TICK_PAUSE: rd_val[PET_NUM_TICKS-1:0] = pause_r;
      PET_OFS_TICK_COUNT: rd_val[PET_PERIOD_W-1:0] = tick_count[tick_sel_r];
      default: rd_val[PET_CFG_W-1:0] = is_cfg_addr(avs_address) ? cfg_r[cfg_idx] : '0;
    endcase
    if ((avs_read || avs_write) && wait_r)
    begin
      wait_nxt  = 1'b0;
      rdata_nxt = avs_read ? rd_val : 32'h0;
    end
    if (avs_write && !wait_r)
    begin
      wmerge = be_merge((avs_address == PET_OFS_IRQ_STATUS) ? 32'h0 : rd_val, avs_writedata,
                        avs_byteenable);
      case (avs_address)
        PET_OFS_OUT_DATA:   out_data_nxt = wmerge[PET_NUM_PINS-1:0];
        PET_OFS_IRQ_STATUS: st_clr = wmerge[PET_ST_W-1:0] & status_r;
        PET_OFS_IRQ_MASK:   mask_nxt = wmerge[PET_ST_W-1:0];
        PET_OFS_TICK_SEL:
        begin
          if (wmerge[2:0] == 3'h0)
          begin
            tick_sel_nxt = PET_TICK_DEFAULT;
          end
          else if (wmerge[2:0] <= PET_TICK_IDX_MAX)
          begin
            tick_sel_nxt = 2'(wmerge[2:0] - 3'h1);
          end
        end
        PET_OFS_TICK_PER:
        begin
          period_nxt[tick_sel_r]  = wmerge[PET_PERIOD_W-1:0];
          restart_nxt[tick_sel_r] = 1'b1;
        end
        PET_OFS_TICK_PAUSE: pause_nxt = wmerge[PET_NUM_TICKS-1:0];
        default:
        begin
          if (is_cfg_addr(avs_address))
          begin
            new_cfg = wmerge[PET_CFG_W-1:0];
            if (cfg_is_edge(new_cfg) && !cfg_is_edge(cfg_r[cfg_idx])
                && armed_cnt >= PET_ARMED_W'(PET_MAX_ARMED))
            begin
              st_set[PET_ST_REFUSE_BIT] = 1'b1;
            end
            else
            begin
              cfg_nxt[cfg_idx] = new_cfg;
            end
          end
        end
      endcase
    end
    status_nxt = (status_r & ~st_clr) | st_set;
    irq_nxt    = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_r     <= 1'b1;
      rdata_r    <= 32'h0;
      out_data_r <= '0;
      status_r   <= '0;
      mask_r     <= '0;
      tick_sel_r <= PET_TICK_DEFAULT;
      pause_r    <= '0;
      restart_r  <= '0;
      irq_r      <= 1'b0;
      period_r   <= '{default: '0};
      cfg_r      <= '{default: '0};
    end
    else
    begin
      wait_r     <= wait_nxt;
      rdata_r    <= rdata_nxt;
      out_data_r <= out_data_nxt;
      status_r   <= status_nxt;
      mask_r     <= mask_nxt;
      tick_sel_r <= tick_sel_nxt;
      pause_r    <= pause_nxt;
      restart_r  <= restart_nxt;
      irq_r      <= irq_nxt;
      period_r   <= period_nxt;
      cfg_r      <= cfg_nxt;
    end
  end

  // Pin drivers and pulls
  always_comb
  begin
    for (int p = 0; p < PET_NUM_PINS; p++)
    begin
      pin_out_nxt[p] = 1'b0;
      pin_oe_nxt[p]  = 1'b0;
      pull_up_nxt[p] = 1'b0;
      pull_dn_nxt[p] = 1'b0;
      case (cfg_mode(cfg_r[p]))
        DIGITAL_OUT_MODE:
        begin
          pin_out_nxt[p] = out_data_r[p] & ~cfg_r[p][PET_CFG_OD_BIT];
          pin_oe_nxt[p]  = ~out_data_r[p] | ~cfg_r[p][PET_CFG_OD_BIT];
        end
        LEGACY_OPEN_DRAIN_OUTPUT_MODE: pin_oe_nxt[p] = ~out_data_r[p];
        DIGITAL_IN_MODE, RISING_EDGE_MODE, FALLING_EDGE_MODE, ANY_EDGE_MODE:
        begin
          pull_up_nxt[p] = cfg_r[p][PET_CFG_PULL_LSB +: PET_CFG_PULL_W] == PULL_UP;
          pull_dn_nxt[p] = cfg_r[p][PET_CFG_PULL_LSB +: PET_CFG_PULL_W] == PULL_DOWN;
        end
        default: pin_oe_nxt[p] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      pull_up_r <= '0;
      pull_dn_r <= '0;
    end
    else
    begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      pull_up_r <= pull_up_nxt;
      pull_dn_r <= pull_dn_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pin_out         = pin_out_r;
  assign pin_oe          = pin_oe_r;
  assign pull_up_en      = pull_up_r;
  assign pull_dn_en      = pull_dn_r;
  assign irq             = irq_r;
endmodule : pet_top
`default_nettype wire

// ### testbench/pet_top_assertions.sv
`default_nettype none
module pet_top_checker
  import pet_pkg::*;
#(
  parameter int MS_CYCLES = PET_MS_CYCLES
)
(
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic [PET_NUM_PINS-1:0] pin_in,
  input wire logic [PET_NUM_PINS-1:0] pin_out,
  input wire logic [PET_NUM_PINS-1:0] pin_oe,
  input wire logic [PET_NUM_PINS-1:0] pull_up_en,
  input wire logic [PET_NUM_PINS-1:0] pull_dn_en,
  input wire logic                    irq
);
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic        rd_ok;

  // Shadow of the mask register
  always_comb
  begin
    mask_nxt = mask_r;
    if (avs_write && !avs_waitrequest && avs_address == PET_OFS_IRQ_MASK)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (avs_byteenable[i])
        begin
          mask_nxt[8*i +: 8] = avs_writedata[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_r <= 32'h0;
    end
    else
    begin
      mask_r <= mask_nxt;
    end
  end

  assign rd_ok = avs_read && !avs_waitrequest;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_pull_excl: assert property (!(|(pull_up_en & pull_dn_en)))
    else $error("pull-up and pull-down together");
  a_drive_nopull: assert property (!(|(pin_oe & (pull_up_en | pull_dn_en))))
    else $error("driven pin also pulled");
  a_arm_limit: assert property (rd_ok && avs_address == PET_OFS_ARMED_CNT |-> avs_readdata <= 32'h0000_000A)
    else $error("armed count above ten");
  a_sel_range: assert property (rd_ok && avs_address == PET_OFS_TICK_SEL |-> avs_readdata inside {[1:4]})
    else $error("timer select outside one to four");
  a_count_width: assert property (rd_ok && avs_address == PET_OFS_TICK_COUNT |-> avs_readdata[31] == 1'b0)
    else $error("timer count wider than 31 bits");
  a_unmapped_zero: assert property (rd_ok && avs_address >= 8'h80 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (!(|mask_r[20:0]) && !$past(|mask_r[20:0]) |-> !irq)
    else $error("irq high with all sources masked");
endmodule : pet_top_checker

bind pet_top pet_top_checker #(.MS_CYCLES(MS_CYCLES)) pet_top_checker_inst (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
  .irq(irq)
);
`default_nettype wire

// ### testbench/pet_pin_model.sv
`default_nettype none
module pet_pin_model
  import pet_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic [PET_NUM_PINS-1:0] ext_en,
  input  wire logic [PET_NUM_PINS-1:0] ext_val,
  input  wire logic [PET_NUM_PINS-1:0] pin_out,
  input  wire logic [PET_NUM_PINS-1:0] pin_oe,
  input  wire logic [PET_NUM_PINS-1:0] pull_up_en,
  input  wire logic [PET_NUM_PINS-1:0] pull_dn_en,
  output logic      [PET_NUM_PINS-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PET_NUM_PINS-1:0] flt_r = '0;

  // Undriven, unpulled pins wander every cycle
  always_ff @(posedge sys_clk)
  begin
    flt_r <= ~flt_r;
  end

  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pull_up_en | (~pull_dn_en & flt_r)));
endmodule : pet_pin_model
`default_nettype wire

// ### testbench/pet_top_bench.sv
`default_nettype none
module pet_top_bench
  import pet_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 8;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] pull_up_en;
  logic [15:0] pull_dn_en;
  logic        irq;
  logic [15:0] ext_en;
  logic [15:0] ext_val;
  logic [31:0] q;
  int          n_mismatch;
  int          n_checks;

  pet_top #(.MS_CYCLES(MS)) pet_top_inst (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .irq(irq));

  pet_pin_model pet_pin_model_inst (.sys_clk(sys_clk), .ext_en(ext_en),
    .ext_val(ext_val), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .pin_lvl(pin_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    chk("bus answer", 32'h2, 32'(n));
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    acc(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask : rdc

  task automatic cfg(input int p, input logic [31:0] v);
    acc(1'b1, 8'(8'h40 + 4 * p), v);
  endtask : cfg

  task automatic wirq(output time t);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (irq !== 1'b1 && n < 200);
    t = $time;
  endtask : wirq

  task automatic t_reset();
    rdc(PET_OFS_OUT_DATA, 32'h0, "out data");
    rdc(PET_OFS_IRQ_MASK, 32'h0, "mask");
    rdc(PET_OFS_TICK_SEL, 32'h1, "tick sel reset");
    rdc(PET_OFS_ARMED_CNT, 32'h0, "armed reset");
    acc(1'b1, 8'h80, 32'hFFFF_FFFF);
    rdc(8'h80, 32'h0, "unmapped");
    chk("irq reset", 32'h0, 32'(irq));
  endtask : t_reset

  task automatic t_edges();
    cfg(0, 32'(RISING_EDGE_MODE));
    cfg(1, 32'(FALLING_EDGE_MODE));
    cfg(2, 32'(ANY_EDGE_MODE));
    cfg(3, 32'(OFF_MODE));
    acc(1'b1, PET_OFS_IRQ_STATUS, 32'h001F_FFFF);
    acc(1'b1, PET_OFS_IRQ_MASK, 32'h1);
    @(posedge sys_clk);
    ext_val <= 16'h000F;
    repeat (8) @(posedge sys_clk);
    chk("irq rise", 32'h1, 32'(irq));
    rdc(PET_OFS_IRQ_STATUS, 32'h5, "rise events");
    acc(1'b1, PET_OFS_IRQ_STATUS, 32'hF);
    @(posedge sys_clk);
    chk("irq clear", 32'h0, 32'(irq));
    ext_val <= 16'h0000;
    repeat (8) @(posedge sys_clk);
    rdc(PET_OFS_IRQ_STATUS, 32'h6, "fall events");
    acc(1'b1, PET_OFS_IRQ_STATUS, 32'hF);
  endtask : t_edges

  task automatic t_pulls();
    cfg(4, 32'h08 | 32'(RISING_EDGE_MODE));
    cfg(5, 32'h10 | 32'(FALLING_EDGE_MODE));
    cfg(6, 32'h18 | 32'(ANY_EDGE_MODE));
    repeat (6) @(posedge sys_clk);
    chk("pull up", 32'h0010, 32'(pull_up_en));
    chk("pull down", 32'h0020, 32'(pull_dn_en));
    acc(1'b0, PET_OFS_PIN_LEVEL, 32'h0);
    chk("armed level", 32'h10, 32'(q[5:0]));
  endtask : t_pulls

  task automatic t_outputs();
    cfg(8, 32'(DIGITAL_OUT_MODE));
    cfg(9, 32'h20 | 32'(DIGITAL_OUT_MODE));
    cfg(10, 32'(LEGACY_OPEN_DRAIN_OUTPUT_MODE));
    acc(1'b1, PET_OFS_OUT_DATA, 32'h0700);
    repeat (2) @(posedge sys_clk);
    chk("drive high", 32'h09, 32'({pin_oe[10:8], pin_out[10:8]}));
    acc(1'b1, PET_OFS_OUT_DATA, 32'h0000);
    repeat (2) @(posedge sys_clk);
    chk("drive low", 32'h38, 32'({pin_oe[10:8], pin_out[10:8]}));
    repeat (4) @(posedge sys_clk);
    acc(1'b0, PET_OFS_PIN_LEVEL, 32'h0);
    chk("driven level", 32'h0, 32'(q[10:8]));
  endtask : t_outputs

  task automatic t_limit();
    for (int p = 11; p < 15; p++)
    begin
      cfg(p, 32'(RISING_EDGE_MODE));
    end
    rdc(PET_OFS_ARMED_CNT, 32'hA, "armed ten");
    cfg(15, 32'(RISING_EDGE_MODE));
    rdc(PET_OFS_ARMED_CNT, 32'hA, "armed limit");
    rdc(8'h7C, 32'h0, "dropped cfg");
    acc(1'b0, PET_OFS_IRQ_STATUS, 32'h0);
    chk("refused flag", 32'h1, 32'(q[20]));
    cfg(0, 32'(FALLING_EDGE_MODE));
    rdc(8'h40, 32'(FALLING_EDGE_MODE), "rearm");
  endtask : t_limit

  task automatic t_ticks();
    time t1;
    time t2;
    for (int i = 1; i < 5; i++)
    begin
      acc(1'b1, PET_OFS_TICK_SEL, 32'(i));
      rdc(PET_OFS_TICK_SEL, 32'(i), "tick sel");
    end
    acc(1'b1, PET_OFS_TICK_SEL, 32'h0);
    acc(1'b1, PET_OFS_TICK_SEL, 32'h5);
    rdc(PET_OFS_TICK_SEL, 32'h1, "tick default");
    acc(1'b1, PET_OFS_TICK_SEL, 32'h3);
    acc(1'b1, PET_OFS_TICK_PER, 32'hFFFF_FFFF);
    rdc(PET_OFS_TICK_PER, 32'h7FFF_FFFF, "period width");
    acc(1'b1, PET_OFS_IRQ_MASK, 32'h0004_0000);
    acc(1'b1, PET_OFS_TICK_PER, 32'h2);
    wirq(t1);
    acc(1'b1, PET_OFS_IRQ_STATUS, 32'h0004_0000);
    wirq(t2);
    chk("tick spacing", 32'(2 * MS), 32'((t2 - t1) / 25));
    acc(1'b1, PET_OFS_TICK_PER, 32'h0);
    acc(1'b1, PET_OFS_IRQ_STATUS, 32'h0004_0000);
    repeat (40) @(posedge sys_clk);
    acc(1'b0, PET_OFS_IRQ_STATUS, 32'h0);
    chk("tick off", 32'h0, 32'(q[18]));
  endtask : t_ticks

  task automatic t_pause();
    logic [31:0] c1;
    acc(1'b1, PET_OFS_TICK_PER, 32'h64);
    repeat (20) @(posedge sys_clk);
    acc(1'b1, PET_OFS_TICK_PAUSE, 32'h4);
    acc(1'b0, PET_OFS_TICK_COUNT, 32'h0);
    c1 = q;
    chk("counted", 32'h1, 32'(c1 != 0));
    repeat (40) @(posedge sys_clk);
    rdc(PET_OFS_TICK_COUNT, c1, "paused count");
    acc(1'b1, PET_OFS_TICK_PAUSE, 32'h0);
    repeat (40) @(posedge sys_clk);
    acc(1'b0, PET_OFS_TICK_COUNT, 32'h0);
    chk("resumed", 32'h1, 32'(q > c1 && q < c1 + 8));
  endtask : t_pause

  initial
  begin
    #(20000 * 25);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ext_en = 16'hF80F;
    ext_val = 16'h0000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_edges();
    t_pulls();
    t_outputs();
    t_limit();
    t_ticks();
    t_pause();
    summarize();
  end
endmodule : pet_top_bench
`default_nettype wire
